// file: hw/scdm_defines.svh
`ifndef SCDM_DEFINES_SVH
`define SCDM_DEFINES_SVH
// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define SCDM_OFS_CTRL 8'h00
`define SCDM_OFS_THR 8'h04
`define SCDM_OFS_RXBASE 8'h08
`define SCDM_OFS_TXBASE 8'h0C
`define SCDM_OFS_STAT 8'h10
// ---------------------------------------------
// Field positions and reset values
// ---------------------------------------------
`define SCDM_CTRL_RXEN 0
`define SCDM_CTRL_TXEN 1
`define SCDM_CTRL_RXGBL 2
`define SCDM_CTRL_TXGBL 3
`define SCDM_STAT_IRQ 0
`define SCDM_STAT_OVR 1
`define SCDM_STAT_UND 2
`define SCDM_STAT_NOBUF 3
`define SCDM_RX_THR_RST 4'h4
`define SCDM_TX_THR_RST 4'h2
// ---------------------------------------------
// Descriptor layout, word and FIFO sizes
// ---------------------------------------------
`define SCDM_BD_OWN 31
`define SCDM_BD_WRAP 30
`define SCDM_BD_LAST 29
`define SCDM_BD_PTR_OFS 32'h4
`define SCDM_WORD_BYTES 16'h4
`define SCDM_LAST_BIT 5'h1F
`define SCDM_FIFO_DEPTH 8
`endif

// file: hw/scdm_pkg.sv
package scdm_pkg;
  typedef enum logic [3:0] {
    SCDM_IDLE = 4'h0,
    SCDM_RX_BD = 4'h1,
    SCDM_RX_BA = 4'h3,
    SCDM_RX_MOVE = 4'h2,
    SCDM_RX_WR = 4'h6,
    SCDM_RX_CLOSE = 4'h7,
    SCDM_TX_BD = 4'h5,
    SCDM_TX_BA = 4'h4,
    SCDM_TX_RD = 4'hC,
    SCDM_TX_PUSH = 4'hD,
    SCDM_TX_CLOSE = 4'hF
  } scdm_state_e;

  typedef struct packed {
    logic last;
    logic [31:0] data;
  } scdm_fent_s;

  typedef struct packed {
    logic we;
    logic global_snoop_flag;
    logic [31:0] addr;
    logic [31:0] wdata;
  } scdm_mreq_s;
endpackage

// file: hw/scdm_top.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`include "scdm_defines.svh"

// ---------------------------------------------
// Word FIFO
// ---------------------------------------------
module scdm_fifo (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic push,
  input wire scdm_pkg::scdm_fent_s wdata,
  input wire logic pop,
  output scdm_pkg::scdm_fent_s rdata,
  output logic [3:0] level,
  output logic full,
  output logic empty
);
  scdm_pkg::scdm_fent_s mem_ff [`SCDM_FIFO_DEPTH];
  logic [2:0] wp_ff;
  logic [2:0] rp_ff;
  logic [3:0] lvl_ff;
  logic do_push;
  logic do_pop;

  assign full = (lvl_ff == 4'(`SCDM_FIFO_DEPTH));
  assign empty = (lvl_ff == 4'h0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign rdata = mem_ff[rp_ff];
  assign level = lvl_ff;

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
    begin
      mem_ff[wp_ff] <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_ff <= 3'h0;
      rp_ff <= 3'h0;
      lvl_ff <= 4'h0;
    end
    else
    begin
      wp_ff <= wp_ff + 3'(do_push);
      rp_ff <= rp_ff + 3'(do_pop);
      lvl_ff <= lvl_ff + 4'(do_push) - 4'(do_pop);
    end
  end
endmodule

// Operation
// R01: Decode received line coding and find each data unit's start and end.
// R02: Assemble received bits into 32-bit words and write them into the receive FIFO.
// R03: Request service once receive FIFO level reaches the programmed threshold.
// R04: On receive service, fetch next receive descriptor giving buffer address and length.
// R05: Move FIFO words via temporary register into memory, then close descriptor.
// R06: Raise processor interrupt after a complete received unit is stored.
// R07: Repeat FIFO service per unit; close full buffer and continue in next descriptor.
// R08: With transmit enabled, start at first descriptor and poll its ready flag.
// R09: For a ready descriptor, read buffer into temporary register, then into transmit FIFO.
// R10: Request more transmit data when FIFO drains to the programmed low threshold.
// R11: Serialise transmit FIFO words, line-encode them and drive them on the port.
// R12: Repeat fetch and refill until every byte of the buffer is loaded and sent.
// R13: Coherency selectable per channel and direction through function-code bits.
// R14: Global transactions request cache snooping; others pass through without snoop.
// R15: After a buffer is sent, clear its ready flag and advance to next descriptor; the code clears it once the last word is pushed into the FIFO.
// R16: After a descriptor marked as table end, wrap back to the first descriptor.
module scdm_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic mem_req,
  output scdm_pkg::scdm_mreq_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rx_sd,
  input wire logic rx_fs,
  output logic tx_sd,
  output logic tx_fs,
  output logic irq
);
  scdm_pkg::scdm_state_e st_ff;
  scdm_pkg::scdm_mreq_s mem_ff;
  scdm_pkg::scdm_fent_s rx_wr;
  scdm_pkg::scdm_fent_s rx_rd;
  scdm_pkg::scdm_fent_s tx_wr;
  scdm_pkg::scdm_fent_s tx_rd;
  logic hready_ff, hresp_ff, mreq_ff, wr_pend_ff, irq_ff;
  logic [31:0] hrdata_ff, tmp_ff, rx_base_ff, tx_base_ff;
  logic [7:0] wr_addr_ff;
  logic [3:0] ctrl_ff, stat_ff, rx_thr_ff, tx_thr_ff;
  logic [3:0] rx_lvl, tx_lvl;
  logic rx_full, rx_empty, tx_full, tx_empty;
  logic rx_sd_m_ff, rx_sd_s_ff, rx_sd_p_ff, rx_fs_m_ff, rx_fs_s_ff, rx_fs_p_ff;
  logic [31:0] rx_sh_ff, rx_sh_nxt;
  logic [4:0] rx_bcnt_ff, tx_bcnt_ff;
  logic rx_bit, rx_end, rx_push, rx_pop, rx_req;
  logic tx_sd_ff, tx_fs_ff, tx_act_ff, tx_lastw_ff, tx_pop, tx_req;
  logic [31:0] tx_sh_ff;
  logic rx_open_ff, rx_wrap_ff, rx_lastw_ff, tx_open_ff, tx_wrap_ff, tx_last_ff;
  logic [7:0] rx_idx_ff, tx_idx_ff;
  logic [31:0] rx_addr_ff, tx_addr_ff;
  logic [15:0] rx_left_ff, rx_used_ff, tx_left_ff, tx_len_ff;
  logic acked, ev_done, ev_nobuf, ev_ovr, ev_und;

  function automatic logic [31:0] bd_addr(input logic [31:0] base, input logic [7:0] idx, input logic ptr);
    bd_addr = base + {21'h0, idx, 3'h0} + (ptr ? `SCDM_BD_PTR_OFS : 32'h0);
  endfunction

  function automatic logic [15:0] sub_word(input logic [15:0] v);
    sub_word = (v > `SCDM_WORD_BYTES) ? v - `SCDM_WORD_BYTES : 16'h0;
  endfunction

  function automatic scdm_pkg::scdm_mreq_s mk_req(input logic we, input logic global_snoop_flag, input logic [31:0] a,
                                                  input logic [31:0] d);
    mk_req = '{we: we, global_snoop_flag: global_snoop_flag, addr: a, wdata: d};
  endfunction

  assign hreadyout = hready_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;
  assign mem_req = mreq_ff;
  assign mem_cmd = mem_ff;
  assign tx_sd = tx_sd_ff;
  assign tx_fs = tx_fs_ff;
  assign irq = irq_ff;

  // ---------------------------------------------
  // Bus slave
  // ---------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
    end
    else
    begin
      wr_pend_ff <= hsel && htrans[1] && hwrite && hready;
      if (hsel && htrans[1] && hready)
      begin
        wr_addr_ff <= haddr[7:0];
        if (!hwrite)
        begin
          if (haddr[7:0] == `SCDM_OFS_CTRL)
            hrdata_ff <= {28'h0, ctrl_ff};
          else if (haddr[7:0] == `SCDM_OFS_THR)
            hrdata_ff <= {20'h0, tx_thr_ff, 4'h0, rx_thr_ff};
          else if (haddr[7:0] == `SCDM_OFS_RXBASE)
            hrdata_ff <= rx_base_ff;
          else if (haddr[7:0] == `SCDM_OFS_TXBASE)
            hrdata_ff <= tx_base_ff;
          else if (haddr[7:0] == `SCDM_OFS_STAT)
            hrdata_ff <= {tx_idx_ff, rx_idx_ff, tx_lvl, rx_lvl, st_ff, stat_ff};
          else
            hrdata_ff <= 32'h0;
        end
      end
    end
  end

  // ---------------------------------------------
  // Configuration
  // ---------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff <= 4'h0;
      rx_thr_ff <= `SCDM_RX_THR_RST;
      tx_thr_ff <= `SCDM_TX_THR_RST;
      rx_base_ff <= 32'h0;
      tx_base_ff <= 32'h0;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == `SCDM_OFS_CTRL)
        ctrl_ff <= hwdata[3:0]; // [R13]
      else if (wr_addr_ff == `SCDM_OFS_THR)
      begin
        rx_thr_ff <= hwdata[3:0];
        tx_thr_ff <= hwdata[11:8];
      end
      else if (wr_addr_ff == `SCDM_OFS_RXBASE)
        rx_base_ff <= hwdata;
      else if (wr_addr_ff == `SCDM_OFS_TXBASE)
        tx_base_ff <= hwdata;
    end
  end

  // ---------------------------------------------
  // Status and interrupt
  // ---------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_ff <= 4'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= (stat_ff & ~((wr_pend_ff && wr_addr_ff == `SCDM_OFS_STAT) ? hwdata[3:0] : 4'h0))
                 | {ev_nobuf, ev_und, ev_ovr, ev_done};
      irq_ff <= ev_done || (irq_ff && !(wr_pend_ff && wr_addr_ff == `SCDM_OFS_STAT
                                         && hwdata[`SCDM_STAT_IRQ])); // [R06]
    end
  end

  // ---------------------------------------------
  // Receive deserialiser
  // ---------------------------------------------
  assign rx_bit = ~(rx_sd_s_ff ^ rx_sd_p_ff); // [R01]
  assign rx_end = rx_fs_p_ff && !rx_fs_s_ff; // [R01]
  assign rx_sh_nxt = {rx_bit, rx_sh_ff[31:1]};
  assign rx_push = ctrl_ff[`SCDM_CTRL_RXEN] && ((rx_fs_s_ff && rx_bcnt_ff == `SCDM_LAST_BIT) || rx_end);
  assign rx_wr.last = rx_end;
  assign rx_wr.data = rx_end ? (rx_sh_ff >> (6'd32 - {1'b0, rx_bcnt_ff})) : rx_sh_nxt; // [R02]
  assign ev_ovr = rx_push && rx_full;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_sd_m_ff <= 1'b0;
      rx_sd_s_ff <= 1'b0;
      rx_sd_p_ff <= 1'b0;
      rx_fs_m_ff <= 1'b0;
      rx_fs_s_ff <= 1'b0;
      rx_fs_p_ff <= 1'b0;
      rx_sh_ff <= 32'h0;
      rx_bcnt_ff <= 5'h0;
    end
    else
    begin
      rx_sd_m_ff <= rx_sd;
      rx_sd_s_ff <= rx_sd_m_ff;
      rx_sd_p_ff <= rx_sd_s_ff;
      rx_fs_m_ff <= rx_fs;
      rx_fs_s_ff <= rx_fs_m_ff;
      rx_fs_p_ff <= rx_fs_s_ff;
      if (rx_fs_s_ff)
      begin
        rx_sh_ff <= rx_sh_nxt; // [R02]
        rx_bcnt_ff <= rx_bcnt_ff + 5'h1;
      end
      else
        rx_bcnt_ff <= 5'h0;
    end
  end

  assign rx_req = ctrl_ff[`SCDM_CTRL_RXEN] && !rx_empty && (rx_lvl >= rx_thr_ff || !rx_fs_s_ff); // [R03]
  assign rx_pop = (st_ff == scdm_pkg::SCDM_RX_MOVE) && rx_left_ff != 16'h0 && !rx_empty;

  scdm_fifo u_rx_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .push(rx_push),
    .wdata(rx_wr),
    .pop(rx_pop),
    .rdata(rx_rd),
    .level(rx_lvl),
    .full(rx_full),
    .empty(rx_empty)
  );

  // ---------------------------------------------
  // Transmit serialiser
  // ---------------------------------------------
  assign tx_pop = ctrl_ff[`SCDM_CTRL_TXEN] && !tx_empty
                  && (!tx_act_ff || (tx_bcnt_ff == `SCDM_LAST_BIT && !tx_lastw_ff));
  assign ev_und = tx_act_ff && tx_bcnt_ff == `SCDM_LAST_BIT && !tx_lastw_ff && tx_empty;
  assign tx_req = !tx_full && tx_lvl <= tx_thr_ff; // [R10]
  assign tx_wr.last = tx_last_ff && tx_left_ff <= `SCDM_WORD_BYTES;
  assign tx_wr.data = tmp_ff; // [R09]

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_sd_ff <= 1'b1;
      tx_fs_ff <= 1'b0;
      tx_act_ff <= 1'b0;
      tx_lastw_ff <= 1'b0;
      tx_sh_ff <= 32'h0;
      tx_bcnt_ff <= 5'h0;
    end
    else
    begin
      tx_fs_ff <= tx_act_ff;
      if (tx_act_ff)
      begin
        tx_sd_ff <= tx_sh_ff[0] ? tx_sd_ff : ~tx_sd_ff; // [R11]
        tx_sh_ff <= {1'b0, tx_sh_ff[31:1]};
        tx_bcnt_ff <= tx_bcnt_ff + 5'h1;
      end
      if (tx_pop)
      begin
        tx_sh_ff <= tx_rd.data; // [R11]
        tx_lastw_ff <= tx_rd.last;
        tx_act_ff <= 1'b1;
      end
      else if (tx_act_ff && tx_bcnt_ff == `SCDM_LAST_BIT)
        tx_act_ff <= 1'b0;
    end
  end

  scdm_fifo u_tx_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .push(st_ff == scdm_pkg::SCDM_TX_PUSH),
    .wdata(tx_wr),
    .pop(tx_pop),
    .rdata(tx_rd),
    .level(tx_lvl),
    .full(tx_full),
    .empty(tx_empty)
  );

  // ---------------------------------------------
  // Descriptor engine
  // ---------------------------------------------
  assign acked = mreq_ff && mem_ack;
  assign ev_done = acked && st_ff == scdm_pkg::SCDM_RX_CLOSE && rx_lastw_ff;
  assign ev_nobuf = acked && st_ff == scdm_pkg::SCDM_RX_BD && !mem_rdata[`SCDM_BD_OWN];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= scdm_pkg::SCDM_IDLE;
      mreq_ff <= 1'b0;
      mem_ff <= '0;
      tmp_ff <= 32'h0;
      rx_open_ff <= 1'b0;
      rx_wrap_ff <= 1'b0;
      rx_lastw_ff <= 1'b0;
      rx_idx_ff <= 8'h00;
      rx_addr_ff <= 32'h0;
      rx_left_ff <= 16'h0;
      rx_used_ff <= 16'h0;
      tx_open_ff <= 1'b0;
      tx_wrap_ff <= 1'b0;
      tx_last_ff <= 1'b0;
      tx_idx_ff <= 8'h00;
      tx_addr_ff <= 32'h0;
      tx_left_ff <= 16'h0;
      tx_len_ff <= 16'h0;
    end
    else
    begin
      if (acked)
        mreq_ff <= 1'b0;
      case (st_ff)
        scdm_pkg::SCDM_IDLE:
        begin
          if (rx_req)
            st_ff <= rx_open_ff ? scdm_pkg::SCDM_RX_MOVE : scdm_pkg::SCDM_RX_BD; // [R04] [R07]
          else if (ctrl_ff[`SCDM_CTRL_TXEN] && (!tx_open_ff || tx_req))
            st_ff <= tx_open_ff ? scdm_pkg::SCDM_TX_RD : scdm_pkg::SCDM_TX_BD; // [R08] [R10]
        end
        scdm_pkg::SCDM_RX_BD, scdm_pkg::SCDM_RX_BA:
        begin
          if (!mreq_ff)
          begin
            mreq_ff <= 1'b1;
            mem_ff <= mk_req(1'b0, ctrl_ff[`SCDM_CTRL_RXGBL], bd_addr(rx_base_ff, rx_idx_ff,
                             st_ff == scdm_pkg::SCDM_RX_BA), 32'h0); // [R04] [R13] [R14]
          end
          else if (acked && st_ff == scdm_pkg::SCDM_RX_BD)
          begin
            rx_left_ff <= mem_rdata[15:0]; // [R04]
            rx_wrap_ff <= mem_rdata[`SCDM_BD_WRAP];
            rx_used_ff <= 16'h0;
            st_ff <= mem_rdata[`SCDM_BD_OWN] ? scdm_pkg::SCDM_RX_BA : scdm_pkg::SCDM_IDLE;
          end
          else if (acked)
          begin
            rx_addr_ff <= mem_rdata; // [R04]
            rx_open_ff <= 1'b1;
            st_ff <= scdm_pkg::SCDM_RX_MOVE;
          end
        end
        scdm_pkg::SCDM_RX_MOVE:
        begin
          if (rx_left_ff == 16'h0)
          begin
            rx_lastw_ff <= 1'b0;
            st_ff <= scdm_pkg::SCDM_RX_CLOSE; // [R07]
          end
          else if (!rx_empty)
          begin
            tmp_ff <= rx_rd.data; // [R05]
            rx_lastw_ff <= rx_rd.last;
            st_ff <= scdm_pkg::SCDM_RX_WR;
          end
          else
            st_ff <= scdm_pkg::SCDM_IDLE; // [R07]
        end
        scdm_pkg::SCDM_RX_WR:
        begin
          if (!mreq_ff)
          begin
            mreq_ff <= 1'b1;
            mem_ff <= mk_req(1'b1, ctrl_ff[`SCDM_CTRL_RXGBL], rx_addr_ff, tmp_ff); // [R05] [R14]
          end
          else if (acked)
          begin
            rx_addr_ff <= rx_addr_ff + 32'(`SCDM_WORD_BYTES);
            rx_left_ff <= sub_word(rx_left_ff);
            rx_used_ff <= rx_used_ff + `SCDM_WORD_BYTES;
            st_ff <= rx_lastw_ff ? scdm_pkg::SCDM_RX_CLOSE : scdm_pkg::SCDM_RX_MOVE;
          end
        end
        scdm_pkg::SCDM_RX_CLOSE:
        begin
          if (!mreq_ff)
          begin
            mreq_ff <= 1'b1;
            mem_ff <= mk_req(1'b1, ctrl_ff[`SCDM_CTRL_RXGBL], bd_addr(rx_base_ff, rx_idx_ff, 1'b0),
                             {1'b0, rx_wrap_ff, rx_lastw_ff, 13'h0, rx_used_ff}); // [R05]
          end
          else if (acked)
          begin
            rx_open_ff <= 1'b0;
            rx_idx_ff <= rx_wrap_ff ? 8'h00 : rx_idx_ff + 8'h01; // [R16]
            st_ff <= scdm_pkg::SCDM_IDLE;
          end
        end
        scdm_pkg::SCDM_TX_BD, scdm_pkg::SCDM_TX_BA:
        begin
          if (!mreq_ff)
          begin
            mreq_ff <= 1'b1;
            mem_ff <= mk_req(1'b0, ctrl_ff[`SCDM_CTRL_TXGBL], bd_addr(tx_base_ff, tx_idx_ff,
                             st_ff == scdm_pkg::SCDM_TX_BA), 32'h0); // [R08] [R13] [R14]
          end
          else if (acked && st_ff == scdm_pkg::SCDM_TX_BD)
          begin
            tx_left_ff <= mem_rdata[15:0];
            tx_len_ff <= mem_rdata[15:0];
            tx_wrap_ff <= mem_rdata[`SCDM_BD_WRAP];
            tx_last_ff <= mem_rdata[`SCDM_BD_LAST];
            st_ff <= mem_rdata[`SCDM_BD_OWN] ? scdm_pkg::SCDM_TX_BA : scdm_pkg::SCDM_IDLE; // [R08]
          end
          else if (acked)
          begin
            tx_addr_ff <= mem_rdata;
            tx_open_ff <= 1'b1;
            st_ff <= scdm_pkg::SCDM_TX_RD;
          end
        end
        scdm_pkg::SCDM_TX_RD:
        begin
          if (tx_left_ff == 16'h0)
            st_ff <= scdm_pkg::SCDM_TX_CLOSE; // [R12]
          else if (!mreq_ff && tx_full)
            st_ff <= scdm_pkg::SCDM_IDLE;
          else if (!mreq_ff)
          begin
            mreq_ff <= 1'b1;
            mem_ff <= mk_req(1'b0, ctrl_ff[`SCDM_CTRL_TXGBL], tx_addr_ff, 32'h0); // [R09] [R14]
          end
          else if (acked)
          begin
            tmp_ff <= mem_rdata; // [R09]
            st_ff <= scdm_pkg::SCDM_TX_PUSH;
          end
        end
        scdm_pkg::SCDM_TX_PUSH:
        begin
          tx_addr_ff <= tx_addr_ff + 32'(`SCDM_WORD_BYTES);
          tx_left_ff <= sub_word(tx_left_ff); // [R12]
          st_ff <= scdm_pkg::SCDM_TX_RD;
        end
        scdm_pkg::SCDM_TX_CLOSE:
        begin
          if (!mreq_ff)
          begin
            mreq_ff <= 1'b1;
            mem_ff <= mk_req(1'b1, ctrl_ff[`SCDM_CTRL_TXGBL], bd_addr(tx_base_ff, tx_idx_ff, 1'b0),
                             {1'b0, tx_wrap_ff, tx_last_ff, 13'h0, tx_len_ff}); // [R15]
          end
          else if (acked)
          begin
            tx_open_ff <= 1'b0;
            tx_idx_ff <= tx_wrap_ff ? 8'h00 : tx_idx_ff + 8'h01; // [R15] [R16]
            st_ff <= scdm_pkg::SCDM_IDLE;
          end
        end
        default:
          st_ff <= scdm_pkg::SCDM_IDLE;
      endcase
    end
  end
endmodule

// file: tb/scdm_top_properties.sv
// --------------------
// Port checker
// --------------------
module scdm_top_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic mem_req,
  input wire scdm_pkg::scdm_mreq_s mem_cmd,
  input wire logic mem_ack,
  input wire logic tx_sd,
  input wire logic tx_fs,
  input wire logic irq
);
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic [3:0] ctrl_ff;
  logic [4:0] fs_cnt_ff;
  logic [3:0] wr_age_ff;
  logic clr_w;
  assign clr_w = dp_wr_ff && (dp_addr_ff == 8'h10) && hwdata[0];
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      ctrl_ff <= 4'h0;
    end
    else
    begin
      dp_wr_ff <= hsel && htrans[1] && hready && hwrite;
      dp_addr_ff <= haddr[7:0];
      if (dp_wr_ff && (dp_addr_ff == 8'h00))
        ctrl_ff <= hwdata[3:0];
    end
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fs_cnt_ff <= 5'h00;
    else
      fs_cnt_ff <= tx_fs ? fs_cnt_ff + 5'h01 : 5'h00;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      wr_age_ff <= 4'hF;
    else if (mem_req && mem_ack && mem_cmd.we)
      wr_age_ff <= 4'h0;
    else if (wr_age_ff != 4'hF)
      wr_age_ff <= wr_age_ff + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_cmd);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("mem request dropped or changed before ack");
  property p_req_drop;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("mem request still up after ack");
  property p_addr_align;
    mem_req |-> mem_cmd.addr[1:0] == 2'h0;
  endproperty
  a_addr_align: assert property (p_addr_align) else $error("mem address not word aligned");
  property p_gbl;
    mem_req && (ctrl_ff[2] == ctrl_ff[3]) |-> mem_cmd.global_snoop_flag == ctrl_ff[2];
  endproperty
  a_gbl: assert property (p_gbl) else $error("snoop flag differs from control");
  property p_fs_len;
    $fell(tx_fs) |-> fs_cnt_ff == 5'h00;
  endproperty
  a_fs_len: assert property (p_fs_len) else $error("tx frame not whole words");
  property p_idle;
    !tx_fs && !$past(tx_fs) |-> $stable(tx_sd);
  endproperty
  a_idle: assert property (p_idle) else $error("tx line moved outside frame");
  property p_irq_rise;
    $rose(irq) |-> wr_age_ff <= 4'h3;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without a stored write");
  property p_irq_stay;
    irq && !clr_w |=> irq;
  endproperty
  a_irq_stay: assert property (p_irq_stay) else $error("irq dropped without clear");
endmodule

bind scdm_top scdm_top_props u_props (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .mem_req(mem_req),
  .mem_cmd(mem_cmd),
  .mem_ack(mem_ack),
  .tx_sd(tx_sd),
  .tx_fs(tx_fs),
  .irq(irq)
);

// file: tb/scdm_mem_model.sv
// --------------------
// Memory partner
// --------------------
module scdm_mem_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic mem_req,
  input wire scdm_pkg::scdm_mreq_s mem_cmd,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:63];
  logic [1:0] wait_ff;
  // Read data is only valid with ack; otherwise it flips each cycle
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_ack && (!slow || wait_ff == 2'h3))
    begin
      mem_ack <= 1'b1;
      wait_ff <= 2'h0;
      mem_rdata <= mem[mem_cmd.addr[7:2]];
      if (mem_cmd.we)
        mem[mem_cmd.addr[7:2]] <= mem_cmd.wdata;
    end
    else
    begin
      mem_ack <= 1'b0;
      wait_ff <= mem_req ? wait_ff + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// file: tb/test_scdm_top.sv
// --------------------
// Testbench
// --------------------
module test_scdm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rx_sd = 1'b1;
  logic rx_fs = 1'b0;
  logic slow = 1'b0;
  logic lvl = 1'b1;
  logic hready, hreadyout, hresp, mem_req, mem_ack, tx_sd, tx_fs, irq, prev;
  logic [31:0] hrdata, mem_rdata, rd, txw;
  scdm_pkg::scdm_mreq_s mem_cmd;
  int miscompares = 0;
  int num_checks = 0;
  assign hready = hreadyout;
  always #20 sys_clk = ~sys_clk;
  scdm_top dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rx_sd(rx_sd), .rx_fs(rx_fs), .tx_sd(tx_sd), .tx_fs(tx_fs), .irq(irq));
  scdm_mem_model u_mem (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic send_rx(input logic [31:0] w);
    for (int i = 0; i < 32; i++)
    begin
      if (!w[i])
        lvl = ~lvl;
      rx_sd <= lvl;
      rx_fs <= 1'b1;
      @(posedge sys_clk);
    end
    rx_fs <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_reset;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check("hreadyout", 32'h1, hreadyout);
    check("hresp", 32'h0, hresp);
    check("tx_sd", 32'h1, tx_sd);
    check("tx_fs", 32'h0, tx_fs);
    check("irq", 32'h0, irq);
    check("mem_req", 32'h0, mem_req);
    $display("reset test done");
  endtask
  task automatic t_regs;
    ahb(1'b0, 8'h04, 32'h0);
    check("thr", 32'h00000204, rd);
    ahb(1'b0, 8'h00, 32'h0);
    check("ctrl", 32'h0, rd);
    ahb(1'b1, 8'h0C, 32'h20);
    ahb(1'b0, 8'h0C, 32'h0);
    check("txbase", 32'h20, rd);
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);
    ahb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    $display("register test done");
  endtask
  task automatic t_rx;
    u_mem.mem[0] = 32'h80000004;
    u_mem.mem[1] = 32'h40;
    u_mem.mem[2] = 32'hC0000010;
    u_mem.mem[3] = 32'h50;
    u_mem.mem[16] = 32'h5A5A5A5A;
    u_mem.mem[20] = 32'h5A5A5A5A;
    slow <= 1'b1;
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b1, 8'h00, 32'hD);
    send_rx(32'h12345678);
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge sys_clk);
    check("irq set", 32'h1, irq);
    check("rx data", 32'h12345678, u_mem.mem[16]);
    check("rx close", 32'h0, u_mem.mem[20]);
    check("rx desc0", 32'h00000004, u_mem.mem[0]);
    check("rx desc1", 32'h60000004, u_mem.mem[2]);
    ahb(1'b0, 8'h10, 32'h0);
    check("rx idx", 32'h0, rd[23:16]);
    check("rx stat", 32'h0001, rd[15:0]);
    ahb(1'b1, 8'h10, 32'h1);
    repeat (2) @(posedge sys_clk);
    check("irq clear", 32'h0, irq);
    $display("receive test done");
  endtask
  task automatic t_tx;
    u_mem.mem[8] = 32'h60000004;
    u_mem.mem[9] = 32'h60;
    u_mem.mem[24] = 32'hA5C30F69;
    slow <= 1'b0;
    ahb(1'b1, 8'h00, 32'h2);
    repeat (50) @(posedge sys_clk);
    check("tx wait", 32'h0, tx_fs);
    u_mem.mem[8] = 32'hE0000004;
    prev = tx_sd;
    for (int i = 0; i < 300 && tx_fs !== 1'b1; i++)
    begin
      prev = tx_sd;
      @(negedge sys_clk);
    end
    for (int i = 0; i < 32; i++)
    begin
      txw[i] = (tx_sd === prev);
      prev = tx_sd;
      @(negedge sys_clk);
    end
    check("tx data", 32'hA5C30F69, txw);
    check("tx end", 32'h0, tx_fs);
    for (int i = 0; i < 300 && u_mem.mem[8][31] !== 1'b0; i++) @(negedge sys_clk);
    check("tx own", 32'h0, u_mem.mem[8][31]);
    @(posedge sys_clk);
    ahb(1'b0, 8'h10, 32'h0);
    check("tx idx", 32'h0, rd[31:24]);
    check("tx stat", 32'h0, {rd[15:8], rd[3:0]});
    ahb(1'b1, 8'h00, 32'h0);
    $display("transmit test done");
  endtask
  initial
  begin
    t_reset;
    t_regs;
    t_rx;
    t_tx;
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end
endmodule
